// [design/ncr_pkg.sv]
// Constants and carrier types for the NVM command register interface
package ncr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CMD_CTRL  = 4'h0;
  localparam logic [3:0] IDX_SECT_PROT = 4'h1;
  localparam logic [3:0] IDX_STATUS    = 4'h2;
  localparam logic [3:0] IDX_INT_EN    = 4'h3;
  localparam logic [3:0] IDX_INT_FLAG  = 4'h4;
  localparam logic [3:0] IDX_DATA_LO   = 4'h6;
  localparam logic [3:0] IDX_DATA_HI   = 4'h7;
  localparam logic [3:0] IDX_ADDR_LO   = 4'h8;
  localparam logic [3:0] IDX_ADDR_HI   = 4'h9;
  localparam int         IDX_LSB       = 2;
  localparam int         IDX_MSB       = 5;
  localparam int         PAD_MSB       = 7;
  localparam int         PAD_LSB       = 6;
  // Command codes
  localparam logic [2:0] CMD_NONE       = 3'h0;
  localparam logic [2:0] CMD_WRITE_PAGE = 3'h1;
  localparam logic [2:0] CMD_ERASE_PAGE = 3'h2;
  localparam logic [2:0] CMD_ERASE_WR   = 3'h3;
  localparam logic [2:0] CMD_PB_CLEAR   = 3'h4;
  localparam logic [2:0] CMD_CHIP_ERASE = 3'h5;
  localparam logic [2:0] CMD_EE_ERASE   = 3'h6;
  localparam logic [2:0] CMD_FUSE_WRITE = 3'h7;
  // Field positions
  localparam int BIT_APP_WP    = 0;
  localparam int BIT_BOOT_LOCK = 1;
  localparam int BIT_F_BUSY    = 0;
  localparam int BIT_EE_BUSY   = 1;
  localparam int BIT_WR_ERR    = 2;
  localparam int BIT_EE_READY  = 0;
  // Reset values
  localparam logic [2:0]  RST_CMD  = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // Address at and above which a page command targets the EEPROM
  localparam logic [15:0] EEPROM_BASE = 16'h1400;
  // Page buffer clear stalls the CPU for this many clock cycles
  localparam int         PBC_CYCLES = 7;
  localparam logic [2:0] PBC_LAST   = 3'(PBC_CYCLES - 1);
  localparam logic [2:0] CNT_ZERO   = 3'h0;
  localparam logic [2:0] CNT_ONE    = 3'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PBC  = 2'b10
  } ncr_state_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ncr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ncr_apb_rsp_t;

  typedef struct packed {
    logic        start;
    logic [2:0]  op;
    logic        to_eeprom;
    logic        erase_flash;
    logic        erase_eeprom;
    logic [15:0] addr;
    logic [15:0] data;
  } ncr_nvm_cmd_t;
endpackage

// [design/ncr_top.sv]
// NVM command register interface: APB registers, command issue, protection, status
//
// Notes on behaviour
// - Writing the 3-bit command field issues a command; zero means none.
// - Page commands pick flash or EEPROM from the address register.
// - Chip erase wipes flash and EEPROM, EEPROM kept when preserve fuse set.
// - Fuse write starts only when issued from the debug programming port.
// - With boot lock set, boot reads and fetches return zero.
// - Boot lock writable only from boot code; cleared only by reset.
// - Boot lock enforcement begins when execution first leaves the boot section.
// - Application write protect is set-only, blocks application updates until reset.
// - Write error shows whether the latest operation failed.
// - Busy bits show EEPROM and flash executing a command.
// - EEPROM ready flag set while EEPROM idle; write one clears it only while EEPROM busy.
// - Ready interrupt is a level: enable and flag both set.
// - Data and address registers are low and high byte registers.
// - Data register supplies the value a fuse write programs.
// - Address register follows the last updated memory location.
// - Control writes without the unlock key leave the register unchanged.
// - Page buffer clear fills ones and stalls the CPU seven cycles.
// - Interrupt request stays active until the flag or the enable is cleared.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module ncr_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire ncr_pkg::ncr_apb_req_t apb_req,
  output      ncr_pkg::ncr_apb_rsp_t apb_rsp,
  input  wire logic                  from_debug_port,
  input  wire logic                  spm_key_open,
  input  wire logic                  ioreg_key_open,
  input  wire logic                  exec_in_boot,
  input  wire logic                  addr_in_boot,
  input  wire logic                  addr_in_app,
  input  wire logic                  mixed_section,
  input  wire logic                  eeprom_preserve_fuse,
  input  wire logic                  buf_wr_stb,
  input  wire logic [15:0]           buf_wr_addr,
  input  wire logic                  flash_done,
  input  wire logic                  eeprom_done,
  input  wire logic                  mem_rd_boot,
  input  wire logic [15:0]           mem_rd_raw,
  output      logic [15:0]           mem_rd_data,
  output      ncr_pkg::ncr_nvm_cmd_t nvm_cmd,
  output      logic                  pb_clear,
  output      logic                  cpu_stall,
  output      logic                  eeprom_ready_irq
);
  import ncr_pkg::*;

  logic [2:0]   cmd_ff;
  logic         app_wp_ff;
  logic         lock_wr_ff;
  logic         lock_act_ff;
  logic         f_busy_ff;
  logic         ee_busy_ff;
  logic         wr_err_ff;
  logic         irq_en_ff;
  logic         ee_rdy_ff;
  logic [15:0]  data_ff;
  logic [15:0]  addr_ff;
  logic [31:0]  prdata_ff;
  logic [15:0]  rd_data_ff;
  logic [2:0]   pbc_cnt_ff;
  ncr_state_t   state_ff;
  ncr_nvm_cmd_t cmd_out_ff;

  logic [3:0]   idx;
  logic         mapped;
  logic         acc;
  logic         wr;
  logic [2:0]   code;
  logic         busy;
  logic         is_page;
  logic         tgt_ee;
  logic         bad;
  logic         cmd_ok;
  logic         go;
  logic         set_f;
  logic         set_ee;
  logic [31:0]  rd_val;

  assign idx    = apb_req.paddr[IDX_MSB:IDX_LSB];
  assign acc    = apb_req.psel & apb_req.penable;
  assign wr     = acc & apb_req.pwrite;
  assign code   = apb_req.pwdata[2:0];
  assign busy   = f_busy_ff | ee_busy_ff | (state_ff == ST_PBC);
  assign is_page = (code == CMD_WRITE_PAGE) | (code == CMD_ERASE_PAGE) |
                   (code == CMD_ERASE_WR);
  assign tgt_ee = (addr_ff >= EEPROM_BASE);

  always_comb begin
    mapped = (apb_req.paddr[PAD_MSB:PAD_LSB] == 2'b00) &&
             (apb_req.paddr[IDX_LSB-1:0] == 2'b00);
    case (idx)
      IDX_CMD_CTRL, IDX_SECT_PROT, IDX_STATUS, IDX_INT_EN, IDX_INT_FLAG,
      IDX_DATA_LO, IDX_DATA_HI, IDX_ADDR_LO, IDX_ADDR_HI: ;
      default: mapped = 1'b0;
    endcase
  end

  // Command acceptance
  assign cmd_ok = wr & mapped & (idx == IDX_CMD_CTRL) & spm_key_open &
                  (code != CMD_NONE) & ~busy;
  assign bad = ((code == CMD_FUSE_WRITE) & ~from_debug_port) |
               (is_page & ~tgt_ee & app_wp_ff & addr_in_app) |
               (is_page & ~tgt_ee & lock_act_ff & addr_in_boot) |
               (is_page & mixed_section);
  assign go = cmd_ok & ~bad;
  // Chip erase ignores section protection
  assign set_f  = go & ((is_page & ~tgt_ee) | (code == CMD_CHIP_ERASE) |
                        (code == CMD_FUSE_WRITE));
  assign set_ee = go & ((is_page & tgt_ee) | (code == CMD_EE_ERASE) |
                        ((code == CMD_CHIP_ERASE) & ~eeprom_preserve_fuse));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= RST_CMD;
    end else if (wr && mapped && idx == IDX_CMD_CTRL && spm_key_open) begin
      cmd_ff <= code;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_err_ff <= 1'b0;
    end else if (cmd_ok) begin
      wr_err_ff <= bad;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_out_ff <= '0;
    end else begin
      cmd_out_ff.start        <= go & (code != CMD_PB_CLEAR);
      cmd_out_ff.op           <= code;
      cmd_out_ff.to_eeprom    <= tgt_ee;
      cmd_out_ff.erase_flash  <= code == CMD_CHIP_ERASE;
      cmd_out_ff.erase_eeprom <= set_ee & ~is_page;
      cmd_out_ff.addr         <= addr_ff;
      cmd_out_ff.data         <= data_ff;
    end
  end
  assign nvm_cmd = cmd_out_ff;

  // Busy flags: a start wins over a done in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      f_busy_ff <= 1'b0;
    end else if (set_f) begin
      f_busy_ff <= 1'b1;
    end else if (flash_done) begin
      f_busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ee_busy_ff <= 1'b0;
    end else if (set_ee) begin
      ee_busy_ff <= 1'b1;
    end else if (eeprom_done) begin
      ee_busy_ff <= 1'b0;
    end
  end

  // Page buffer clear sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= ST_IDLE;
      pbc_cnt_ff <= CNT_ZERO;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (go && code == CMD_PB_CLEAR) begin
            state_ff   <= ST_PBC;
            pbc_cnt_ff <= PBC_LAST;
          end
        end
        ST_PBC: begin
          if (pbc_cnt_ff == CNT_ZERO) begin
            state_ff <= ST_IDLE;
          end else begin
            pbc_cnt_ff <= pbc_cnt_ff - CNT_ONE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign cpu_stall = (state_ff == ST_PBC);
  assign pb_clear  = (state_ff == ST_PBC) && (pbc_cnt_ff == PBC_LAST);

  // Section protection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      app_wp_ff <= 1'b0;
    end else if (wr && mapped && idx == IDX_SECT_PROT && ioreg_key_open &&
                 apb_req.pwdata[BIT_APP_WP]) begin
      app_wp_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_wr_ff <= 1'b0;
    end else if (wr && mapped && idx == IDX_SECT_PROT && ioreg_key_open &&
                 exec_in_boot && apb_req.pwdata[BIT_BOOT_LOCK]) begin
      lock_wr_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_act_ff <= 1'b0;
    end else if (lock_wr_ff && !exec_in_boot) begin
      lock_act_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= RST_WORD;
    end else begin
      rd_data_ff <= (lock_act_ff && mem_rd_boot) ? RST_WORD : mem_rd_raw;
    end
  end
  assign mem_rd_data = rd_data_ff;

  // Interrupt enable and ready flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_ff <= 1'b0;
    end else if (wr && mapped && idx == IDX_INT_EN) begin
      irq_en_ff <= apb_req.pwdata[BIT_EE_READY];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ee_rdy_ff <= 1'b0;
    end else if (!ee_busy_ff) begin
      ee_rdy_ff <= 1'b1;
    end else if (wr && mapped && idx == IDX_INT_FLAG && apb_req.pwdata[BIT_EE_READY]) begin
      ee_rdy_ff <= 1'b0;
    end
  end
  assign eeprom_ready_irq = irq_en_ff & ee_rdy_ff;

  // Data and address byte registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ff <= RST_WORD;
    end else if (wr && mapped && idx == IDX_DATA_LO) begin
      data_ff[7:0] <= apb_req.pwdata[7:0];
    end else if (wr && mapped && idx == IDX_DATA_HI) begin
      data_ff[15:8] <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= RST_WORD;
    end else if (buf_wr_stb) begin
      addr_ff <= buf_wr_addr;
    end else if (wr && mapped && idx == IDX_ADDR_LO) begin
      addr_ff[7:0] <= apb_req.pwdata[7:0];
    end else if (wr && mapped && idx == IDX_ADDR_HI) begin
      addr_ff[15:8] <= apb_req.pwdata[7:0];
    end
  end

  // Read data is captured in the setup cycle, answered in the access cycle
  always_comb begin
    rd_val = RD_ZERO;
    case (idx)
      IDX_CMD_CTRL:  rd_val[2:0] = cmd_ff;
      IDX_SECT_PROT: begin
        rd_val[BIT_APP_WP]    = app_wp_ff;
        rd_val[BIT_BOOT_LOCK] = lock_wr_ff;
      end
      IDX_STATUS: begin
        rd_val[BIT_F_BUSY]  = f_busy_ff;
        rd_val[BIT_EE_BUSY] = ee_busy_ff;
        rd_val[BIT_WR_ERR]  = wr_err_ff;
      end
      IDX_INT_EN:    rd_val[BIT_EE_READY] = irq_en_ff;
      IDX_INT_FLAG:  rd_val[BIT_EE_READY] = ee_rdy_ff;
      IDX_DATA_LO:   rd_val[7:0] = data_ff[7:0];
      IDX_DATA_HI:   rd_val[7:0] = data_ff[15:8];
      IDX_ADDR_LO:   rd_val[7:0] = addr_ff[7:0];
      IDX_ADDR_HI:   rd_val[7:0] = addr_ff[15:8];
      default:       rd_val = RD_ZERO;
    endcase
    if (!mapped) begin
      rd_val = RD_ZERO;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff <= RD_ZERO;
    end else if (apb_req.psel && !apb_req.penable) begin
      prdata_ff <= rd_val;
    end
  end

  assign apb_rsp.prdata  = prdata_ff;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~mapped;

  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (eeprom_ready_irq && !(wr && mapped && (idx == IDX_INT_FLAG || idx == IDX_INT_EN)))
      |=> eeprom_ready_irq)
    else $error("ready interrupt dropped while flag and enable stand");

  a_ready_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ee_busy_ff |=> ee_rdy_ff)
    else $error("ready flag not set while EEPROM idle");

  a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busy && wr && idx == IDX_CMD_CTRL) |=> !nvm_cmd.start)
    else $error("command started while busy");

  a_fuse_cpu: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr && idx == IDX_CMD_CTRL && code == CMD_FUSE_WRITE && !from_debug_port)
      |=> !nvm_cmd.start && !$rose(f_busy_ff))
    else $error("fuse write started from the CPU");

  a_pbc_stall: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(cpu_stall) |-> cpu_stall [*7] ##1 !cpu_stall)
    else $error("page buffer clear stall is not seven cycles");

  a_boot_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (lock_act_ff && mem_rd_boot) |=> mem_rd_data == RST_WORD)
    else $error("locked boot read returned data");

  a_wp_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    app_wp_ff |=> app_wp_ff)
    else $error("application write protect cleared without reset");

  a_lock_defer: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (lock_wr_ff && exec_in_boot && !lock_act_ff) |=> !lock_act_ff)
    else $error("boot lock active before leaving the boot section");

  a_key_guard: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr && idx == IDX_CMD_CTRL && !spm_key_open) |=> $stable(cmd_ff))
    else $error("command register changed without key");

  a_chip_save: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (go && code == CMD_CHIP_ERASE && eeprom_preserve_fuse) |=> !$rose(ee_busy_ff))
    else $error("chip erase touched a preserved EEPROM");
endmodule // ncr_top

// [testbench/ncr_nvm_model.sv]
// Far-side model of the NVM arrays: finishes each started command after a set delay
`timescale 1ns/1ps
module ncr_nvm_model (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire ncr_pkg::ncr_nvm_cmd_t nvm_cmd,
  input  wire logic [7:0]            dly,
  output      logic                  flash_done,
  output      logic                  eeprom_done
);
  import ncr_pkg::*;
  logic [7:0] cnt_ff;
  logic       run_ff;

  // One array job at a time; both units report done so no busy bit is left hanging
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff      <= 8'h00;
      run_ff      <= 1'b0;
      flash_done  <= 1'b0;
      eeprom_done <= 1'b0;
    end else begin
      flash_done  <= 1'b0;
      eeprom_done <= 1'b0;
      if (nvm_cmd.start) begin
        run_ff <= 1'b1;
        cnt_ff <= dly;
      end else if (run_ff && cnt_ff == 8'h00) begin
        run_ff      <= 1'b0;
        flash_done  <= 1'b1;
        eeprom_done <= 1'b1;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule // ncr_nvm_model

// [testbench/ncr_top_tb.sv]
// Self-checking testbench for the NVM command register interface
`timescale 1ns/1ps
module ncr_top_tb;
  import ncr_pkg::*;
  logic         sys_clk = 1'b0, rst_b = 1'b0;
  ncr_apb_req_t req     = '0;
  ncr_apb_rsp_t rsp;
  ncr_nvm_cmd_t cmd, last;
  logic         dbg = 1'b0, self_programming_key = 1'b0, ioreg = 1'b0, in_boot = 1'b0, a_boot = 1'b0;
  logic         a_app = 1'b0, mix = 1'b0, keep = 1'b0, bstb = 1'b0, rd_boot = 1'b0;
  logic [15:0]  baddr   = 16'h0000, raw = 16'h0000, rdata;
  logic         f_done, e_done, page_buffer_clear, stall, irq, perr;
  logic [7:0]   dly     = 8'h1E;
  logic [7:0]   bval [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h13};
  int           starts  = 0, stall_n = 0, pbc_n = 0, err_total = 0, check_count = 0;

  ncr_top uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .from_debug_port(dbg), .spm_key_open(self_programming_key), .ioreg_key_open(ioreg),
    .exec_in_boot(in_boot), .addr_in_boot(a_boot), .addr_in_app(a_app),
    .mixed_section(mix), .eeprom_preserve_fuse(keep), .buf_wr_stb(bstb),
    .buf_wr_addr(baddr), .flash_done(f_done), .eeprom_done(e_done),
    .mem_rd_boot(rd_boot), .mem_rd_raw(raw), .mem_rd_data(rdata), .nvm_cmd(cmd),
    .pb_clear(page_buffer_clear), .cpu_stall(stall), .eeprom_ready_irq(irq)
  );
  ncr_nvm_model nvm (
    .sys_clk(sys_clk), .rst_b(rst_b), .nvm_cmd(cmd), .dly(dly),
    .flash_done(f_done), .eeprom_done(e_done)
  );

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (cmd.start === 1'b1) begin
      starts++;
      last = cmd;
    end
    stall_n += int'(stall === 1'b1);
    pbc_n += int'(page_buffer_clear === 1'b1);
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic xfer(input logic [3:0] i, input logic w, input logic [7:0] d,
                      output logic [15:0] q);
    req <= '{paddr: {2'b00, i, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: w,
             pwdata: {24'h00_0000, d}};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata[15:0];
    perr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [15:0] q;
    xfer(i, 1'b1, d, q);
  endtask

  task automatic rd(input logic [3:0] i, output logic [15:0] q);
    xfer(i, 1'b0, 8'h00, q);
  endtask

  task automatic go(input logic [2:0] c);
    self_programming_key <= 1'b1;
    wr(IDX_CMD_CTRL, {5'h00, c});
    self_programming_key <= 1'b0;
  endtask

  task automatic idle;
    logic [15:0] q;
    do rd(IDX_STATUS, q); while (q[1:0] !== 2'b00);
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    test_done;
  end

  initial begin
    logic [15:0] q;
    int          s0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      rd(4'(i), q);
      chk("reset value", (i == 4) ? 16'h0001 : 16'h0000, q);
      chk("unmapped error", 16'(i == 5), 16'(perr));
    end
    for (int i = 0; i < 4; i++) wr(4'(IDX_DATA_LO + i), bval[i]);
    for (int i = 0; i < 4; i++) begin
      rd(4'(IDX_DATA_LO + i), q);
      chk("byte register", {8'h00, bval[i]}, q);
    end
    $display("test reset and byte registers ended");
    s0 = starts;
    wr(IDX_CMD_CTRL, 8'h01);
    wr(IDX_SECT_PROT, 8'h01);
    rd(IDX_CMD_CTRL, q);
    chk("unkeyed command", 16'h0000, q);
    rd(IDX_SECT_PROT, q);
    chk("unkeyed protection", 16'h0000, q);
    go(CMD_FUSE_WRITE);
    rd(IDX_STATUS, q);
    chk("cpu fuse write", 16'h0004, q);
    chk("cpu fuse start", 16'(s0), 16'(starts));
    dbg <= 1'b1;
    go(CMD_FUSE_WRITE);
    dbg <= 1'b0;
    rd(IDX_STATUS, q);
    chk("fuse busy", 16'h0001, q);
    chk("fuse data", 16'h3CA5, last.data);
    chk("fuse op", {13'h0000, CMD_FUSE_WRITE}, {13'h0000, last.op});
    idle;
    $display("test key and fuse write ended");
    for (int c = 1; c < 4; c++) begin
      for (int e = 0; e < 2; e++) begin
        wr(IDX_ADDR_LO, e ? 8'h00 : 8'hFF);
        wr(IDX_ADDR_HI, e ? 8'h14 : 8'h13);
        s0 = starts;
        go(3'(c));
        go(CMD_CHIP_ERASE);
        rd(IDX_STATUS, q);
        chk("page busy", e ? 16'h0002 : 16'h0001, q);
        chk("page target", 16'(e), 16'(last.to_eeprom));
        chk("page op", 16'(c), 16'(last.op));
        chk("page address", e ? 16'h1400 : 16'h13FF, last.addr);
        chk("start while busy", 16'(s0 + 1), 16'(starts));
        idle;
      end
    end
    $display("test page commands ended");
    dly <= 8'hC8;
    go(CMD_EE_ERASE);
    rd(IDX_STATUS, q);
    chk("eeprom erase busy", 16'h0002, q);
    wr(IDX_INT_EN, 8'h01);
    chk("irq held", 16'h0001, 16'(irq));
    wr(IDX_INT_FLAG, 8'h01);
    chk("irq cleared", 16'h0000, 16'(irq));
    rd(IDX_INT_FLAG, q);
    chk("flag cleared", 16'h0000, q);
    idle;
    chk("irq on ready", 16'h0001, 16'(irq));
    wr(IDX_INT_FLAG, 8'h01);
    rd(IDX_INT_FLAG, q);
    chk("flag held idle", 16'h0001, q);
    wr(IDX_INT_EN, 8'h00);
    chk("irq disabled", 16'h0000, 16'(irq));
    dly <= 8'h1E;
    for (int k = 0; k < 2; k++) begin
      keep <= 1'(k);
      go(CMD_CHIP_ERASE);
      rd(IDX_STATUS, q);
      chk("chip erase busy", k ? 16'h0001 : 16'h0003, q);
      chk("chip erase eeprom", 16'(k == 0), 16'(last.erase_eeprom));
      chk("chip erase flash", 16'h0001, 16'(last.erase_flash));
      idle;
    end
    keep <= 1'b0;
    $display("test ready flag and chip erase ended");
    s0 = starts;
    stall_n = 0;
    pbc_n = 0;
    go(CMD_PB_CLEAR);
    repeat (12) @(posedge sys_clk);
    chk("stall cycles", 16'h0007, 16'(stall_n));
    chk("clear pulses", 16'h0001, 16'(pbc_n));
    chk("clear start", 16'(s0), 16'(starts));
    bstb <= 1'b1;
    baddr <= 16'h0123;
    @(posedge sys_clk);
    bstb <= 1'b0;
    rd(IDX_ADDR_LO, q);
    chk("tracked address low", 16'h0023, q);
    rd(IDX_ADDR_HI, q);
    chk("tracked address high", 16'h0001, q);
    ioreg <= 1'b1;
    wr(IDX_SECT_PROT, 8'h01);
    wr(IDX_SECT_PROT, 8'h00);
    rd(IDX_SECT_PROT, q);
    chk("write protect sticky", 16'h0001, q);
    a_app <= 1'b1;
    go(CMD_WRITE_PAGE);
    a_app <= 1'b0;
    rd(IDX_STATUS, q);
    chk("protected page", 16'h0004, q);
    mix <= 1'b1;
    go(CMD_ERASE_PAGE);
    mix <= 1'b0;
    rd(IDX_STATUS, q);
    chk("mixed sections", 16'h0004, q);
    go(CMD_ERASE_PAGE);
    rd(IDX_STATUS, q);
    chk("error replaced", 16'h0001, q);
    idle;
    $display("test page buffer and write protect ended");
    wr(IDX_SECT_PROT, 8'h02);
    rd(IDX_SECT_PROT, q);
    chk("lock outside boot", 16'h0001, q);
    in_boot <= 1'b1;
    wr(IDX_SECT_PROT, 8'h02);
    rd_boot <= 1'b1;
    raw <= 16'h5A5A;
    rd(IDX_SECT_PROT, q);
    chk("lock from boot", 16'h0003, q);
    chk("boot read before leaving", 16'h5A5A, rdata);
    in_boot <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("boot read locked", 16'h0000, rdata);
    rd_boot <= 1'b0;
    a_boot <= 1'b1;
    go(CMD_WRITE_PAGE);
    a_boot <= 1'b0;
    ioreg <= 1'b0;
    rd(IDX_STATUS, q);
    chk("locked boot page", 16'h0004, q);
    chk("other read open", 16'h5A5A, rdata);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(IDX_SECT_PROT, q);
    chk("protection after reset", 16'h0000, q);
    $display("test boot lock and reset ended");
    test_done;
  end
endmodule // ncr_top_tb
